// ==== hw/halfbridge_pwm_freewheel_ctrl.sv ====
// Purpose: PWM and active freewheel command logic for four half-bridges.
// Assumes: pwm_in, node_moving and node_settled are synchronous to pclk.
// Notes:   Guard times are programmed in pclk cycles; zero acts as one in the command and freewheel delay counters.
// Function
// - Decode discharge code to increasing nominal current
// - Suppress freewheeling at very low/high duty
// - Short off time: selected MOSFET driven, load
// - High duty: delay command, opposite MOSFET off
// - Load: no freewheel if off below both guards
// - Short on time: shifted command, load assumed
// - Load: freewheel only when both times suffice
// - Generator: freewheel only when both times suffice
// - Measure switching times into four status registers
// - Rise end missed in blank: rise zero
// - Fall end missed in guard: fall zero
// - Extreme duty: all switching times zero
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module halfbridge_pwm_freewheel_ctrl #(
    parameter int NUM_HB = 4
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NUM_HB-1:0] pwm_in,
    input  wire logic [NUM_HB-1:0] motor_generating,
    input  wire logic [NUM_HB-1:0] node_moving,
    input  wire logic [NUM_HB-1:0] node_settled,
    output logic      [NUM_HB-1:0] hs_gate_on,
    output logic      [NUM_HB-1:0] ls_gate_on,
    output logic      [13:0]       discharge_current [NUM_HB],
    output logic      [13:0]       predischarge_current
);
    // ****************************************************************
    // APB register file
    // ****************************************************************
    logic [31:0] hb_cfg_q [NUM_HB];
    logic [31:0] hb_cfg_d [NUM_HB];
    logic [31:0] glob_q, glob_d, tim_q, tim_d;
    logic [31:0] eff_status_q [NUM_HB];
    logic [31:0] rdata_d;
    logic        err_d, hit_d;
    logic [7:0]  act_cyc, fw_cyc, blank_cyc;
    logic        gen_check_en;

    assign act_cyc      = tim_q[hb_pwm_pkg::ACT_LSB +: 8];
    assign fw_cyc       = tim_q[hb_pwm_pkg::FW_LSB +: 8];
    assign blank_cyc    = tim_q[hb_pwm_pkg::BLANK_LSB +: 8];
    assign gen_check_en = glob_q[hb_pwm_pkg::GENCHK_BIT];
    // Zero wait states keep the master simple; every access ends at once.
    assign pready       = 1'b1;

    always_comb begin
        glob_d  = glob_q;
        tim_d   = tim_q;
        rdata_d = 32'h0000_0000;
        hit_d   = 1'b1;
        for (int i = 0; i < NUM_HB; i++) begin
            hb_cfg_d[i] = hb_cfg_q[i];
        end
        if (paddr == hb_pwm_pkg::GLOBAL_CFG) begin
            rdata_d = glob_q;
            if (pwrite) glob_d = pwdata & 32'h0000_3f01;
        end else if (paddr == hb_pwm_pkg::TIMING_CFG) begin
            rdata_d = tim_q;
            if (pwrite) tim_d = pwdata & 32'h00ff_ffff;
        end else begin
            hit_d = 1'b0;
            for (int i = 0; i < NUM_HB; i++) begin
                if (paddr == hb_pwm_pkg::HB_CFG_BASE + 8'(4 * i)) begin
                    hit_d   = 1'b1;
                    rdata_d = hb_cfg_q[i];
                    if (pwrite) hb_cfg_d[i] = pwdata & 32'h0000_3f07;
                end
                if (paddr == hb_pwm_pkg::EFF_STS_BASE + 8'(4 * i)) begin
                    hit_d   = 1'b1;
                    rdata_d = eff_status_q[i];
                end
            end
        end
        // Status words are read-only; a write there is accepted and dropped.
        err_d = !hit_d;
        if (!(psel && penable && pwrite)) begin
            glob_d = glob_q;
            tim_d  = tim_q;
            for (int i = 0; i < NUM_HB; i++) begin
                hb_cfg_d[i] = hb_cfg_q[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glob_q  <= hb_pwm_pkg::GLOBAL_RST;
            tim_q   <= hb_pwm_pkg::TIMING_RST;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            for (int i = 0; i < NUM_HB; i++) begin
                hb_cfg_q[i] <= hb_pwm_pkg::HB_CFG_RST;
            end
        end else begin
            glob_q  <= glob_d;
            tim_q   <= tim_d;
            prdata  <= (psel && !penable && !pwrite) ? rdata_d : prdata;
            pslverr <= psel && !penable && err_d;
            for (int i = 0; i < NUM_HB; i++) begin
                hb_cfg_q[i] <= hb_cfg_d[i];
            end
        end
    end

    dchg_decode u_pdchg (
        .code         (glob_q[hb_pwm_pkg::PDCHG_LSB +: 6]),
        .current_10ua (predischarge_current)
    );

    // ****************************************************************
    // Per half-bridge command and measurement
    // ****************************************************************
    for (genvar g = 0; g < NUM_HB; g++) begin : g_hb
        logic [1:0] mode;
        logic       afw_en, low_duty, high_duty, extreme, generating;
        logic       load_ok, gen_ok, afw_ok, swap, pwm_is_hs, act_is_hs;
        logic       rise_edge, fall_edge;
        logic [8:0] guard_sum;
        logic       pwm_q, cmd_q, cmd_d, fw_on_q, fw_on_d;
        logic       rpend_q, rpend_d, fpend_q, fpend_d, wpend_q, wpend_d;
        logic [7:0] rt_q, rt_d, ft_q, ft_d, wt_q, wt_d;
        logic [7:0] run_q, run_d, on_len_q, on_len_d, off_len_q, off_len_d;
        hb_pwm_pkg::meas_state_e ms_q, ms_d;
        logic [7:0] mcnt_q, mcnt_d, tdly_q, tdly_d;
        logic [31:0] sts_d;

        assign mode       = hb_cfg_q[g][hb_pwm_pkg::MODE_LSB +: 2];
        assign afw_en     = hb_cfg_q[g][hb_pwm_pkg::AFW_BIT];
        assign rise_edge  = pwm_in[g] && !pwm_q;
        assign fall_edge  = !pwm_in[g] && pwm_q;
        assign guard_sum  = {1'b0, fw_cyc} + {1'b0, act_cyc};
        assign low_duty   = on_len_q < fw_cyc;
        assign high_duty  = off_len_q < act_cyc;
        assign extreme    = low_duty || high_duty;
        assign generating = gen_check_en && motor_generating[g];
        assign load_ok    = on_len_q > fw_cyc && {1'b0, off_len_q} > guard_sum;
        assign gen_ok     = off_len_q > fw_cyc && {1'b0, on_len_q} > guard_sum;
        assign afw_ok     = afw_en && !extreme && (generating ? gen_ok : load_ok);
        // At extreme duty the load case is forced, so the roles never swap.
        assign swap       = generating && afw_ok;
        assign pwm_is_hs  = mode == hb_pwm_pkg::MODE_HS_PWM;
        assign act_is_hs  = pwm_is_hs ^ swap;

        always_comb begin
            run_d     = (rise_edge || fall_edge) ? 8'h01 :
                        (run_q == 8'hff ? run_q : run_q + 8'h01);
            on_len_d  = fall_edge ? run_q : on_len_q;
            off_len_d = rise_edge ? run_q : off_len_q;
            cmd_d     = cmd_q;
            rpend_d   = rpend_q;
            fpend_d   = fpend_q;
            wpend_d   = wpend_q;
            rt_d      = rt_q;
            ft_d      = ft_q;
            wt_d      = wt_q;
            fw_on_d   = fw_on_q;
            // Both edges of the command trail the input by one freewheel guard.
            if (rpend_q) begin
                if (rt_q <= 8'h01) begin
                    cmd_d   = 1'b1;
                    rpend_d = 1'b0;
                end else rt_d = rt_q - 8'h01;
            end
            if (fpend_q) begin
                if (ft_q <= 8'h01) begin
                    cmd_d   = 1'b0;
                    fpend_d = 1'b0;
                    wpend_d = 1'b1;
                    wt_d    = act_cyc;
                end else ft_d = ft_q - 8'h01;
            end
            if (wpend_q) begin
                if (wt_q <= 8'h01) begin
                    fw_on_d = afw_ok;
                    wpend_d = 1'b0;
                end else wt_d = wt_q - 8'h01;
            end
            if (rise_edge) begin
                // Freewheel drops a full guard before the command returns.
                rpend_d = 1'b1;
                rt_d    = fw_cyc;
                wpend_d = 1'b0;
                fw_on_d = 1'b0;
            end
            if (fall_edge) begin
                fpend_d = 1'b1;
                ft_d    = fw_cyc;
            end
            if (mode != hb_pwm_pkg::MODE_LS_PWM && mode != hb_pwm_pkg::MODE_HS_PWM) begin
                cmd_d   = 1'b0;
                fw_on_d = 1'b0;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pwm_q     <= 1'b0;
                cmd_q     <= 1'b0;
                fw_on_q   <= 1'b0;
                rpend_q   <= 1'b0;
                fpend_q   <= 1'b0;
                wpend_q   <= 1'b0;
                rt_q      <= 8'h00;
                ft_q      <= 8'h00;
                wt_q      <= 8'h00;
                run_q     <= 8'h00;
                on_len_q  <= 8'h00;
                off_len_q <= 8'h00;
                hs_gate_on[g] <= 1'b0;
                ls_gate_on[g] <= 1'b0;
            end else begin
                pwm_q     <= pwm_in[g];
                cmd_q     <= cmd_d;
                fw_on_q   <= fw_on_d;
                rpend_q   <= rpend_d;
                fpend_q   <= fpend_d;
                wpend_q   <= wpend_d;
                rt_q      <= rt_d;
                ft_q      <= ft_d;
                wt_q      <= wt_d;
                run_q     <= run_d;
                on_len_q  <= on_len_d;
                off_len_q <= off_len_d;
                hs_gate_on[g] <= act_is_hs ? cmd_d : fw_on_d;
                ls_gate_on[g] <= act_is_hs ? fw_on_d : cmd_d;
            end
        end

        // Measures the active command's turn-on/off delay and edge time.
        always_comb begin
            ms_d   = ms_q;
            mcnt_d = (mcnt_q == 8'hff) ? mcnt_q : mcnt_q + 8'h01;
            tdly_d = tdly_q;
            sts_d  = eff_status_q[g];
            case (ms_q)
                hb_pwm_pkg::M_IDLE: begin
                    mcnt_d = 8'h00;
                    if (cmd_d && !cmd_q) ms_d = hb_pwm_pkg::M_TDON;
                    if (!cmd_d && cmd_q) ms_d = hb_pwm_pkg::M_TDOFF;
                end
                hb_pwm_pkg::M_TDON, hb_pwm_pkg::M_TDOFF: begin
                    if (node_moving[g]) begin
                        tdly_d = mcnt_q;
                        mcnt_d = 8'h00;
                        ms_d   = (ms_q == hb_pwm_pkg::M_TDON) ?
                                 hb_pwm_pkg::M_RISE : hb_pwm_pkg::M_FALL;
                    end else if (mcnt_q >= blank_cyc) begin
                        tdly_d = 8'h00;
                        mcnt_d = 8'h00;
                        ms_d   = (ms_q == hb_pwm_pkg::M_TDON) ?
                                 hb_pwm_pkg::M_RISE : hb_pwm_pkg::M_FALL;
                    end
                end
                hb_pwm_pkg::M_RISE: begin
                    if (node_settled[g] || mcnt_q >= blank_cyc) begin
                        ms_d = hb_pwm_pkg::M_IDLE;
                        sts_d[hb_pwm_pkg::TDON_LSB +: 8]  = extreme ? 8'h00 : tdly_q;
                        sts_d[hb_pwm_pkg::TRISE_LSB +: 8] =
                            (extreme || !node_settled[g]) ? 8'h00 : mcnt_q;
                    end
                end
                hb_pwm_pkg::M_FALL: begin
                    if (node_settled[g] || mcnt_q >= act_cyc) begin
                        ms_d = hb_pwm_pkg::M_IDLE;
                        sts_d[hb_pwm_pkg::TDOFF_LSB +: 8] = extreme ? 8'h00 : tdly_q;
                        sts_d[hb_pwm_pkg::TFALL_LSB +: 8] =
                            (extreme || !node_settled[g]) ? 8'h00 : mcnt_q;
                    end
                end
                default: ms_d = hb_pwm_pkg::M_IDLE;
            endcase
            if (extreme && ms_q != ms_d && ms_d == hb_pwm_pkg::M_IDLE) begin
                sts_d = 32'h0000_0000;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ms_q            <= hb_pwm_pkg::M_IDLE;
                mcnt_q          <= 8'h00;
                tdly_q          <= 8'h00;
                eff_status_q[g] <= 32'h0000_0000;
            end else begin
                ms_q            <= ms_d;
                mcnt_q          <= mcnt_d;
                tdly_q          <= tdly_d;
                eff_status_q[g] <= sts_d;
            end
        end

        dchg_decode u_dchg (
            .code         (hb_cfg_q[g][hb_pwm_pkg::DCHG_LSB +: 6]),
            .current_10ua (discharge_current[g])
        );

        // ************************************************************
        // Checks
        // ************************************************************
        AST_NO_SHOOT: assert property (@(posedge pclk) disable iff (!presetn)
            !(hs_gate_on[g] && ls_gate_on[g]))
            else $error("both gates of one half-bridge on");
        AST_EXTREME_NO_FW: assert property (@(posedge pclk) disable iff (!presetn)
            extreme |=> !fw_on_q || $past(fw_on_q))
            else $error("freewheel started at extreme duty");
        AST_SHORT_OFF_NO_FW: assert property (@(posedge pclk) disable iff (!presetn)
            (wpend_q && wt_q <= 8'h01 && {1'b0, off_len_q} <= guard_sum
             && !generating && !rise_edge) |=> !fw_on_q)
            else $error("freewheel with off time below both guards");
        AST_EXTREME_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
            extreme |-> !swap)
            else $error("roles swapped at extreme duty");
        AST_CMD_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
            (rise_edge && fw_cyc == 8'h03 && !fpend_q && mode == hb_pwm_pkg::MODE_HS_PWM)
            |=> !cmd_q ##1 !cmd_q ##1 !cmd_q ##1 cmd_q)
            else $error("command not delayed by the freewheel guard");
        AST_RISE_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
            (ms_q == hb_pwm_pkg::M_RISE && !node_settled[g] && mcnt_q >= blank_cyc)
            |=> eff_status_q[g][hb_pwm_pkg::TRISE_LSB +: 8] == 8'h00)
            else $error("missed rise end not reported as zero");
        AST_FALL_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
            (ms_q == hb_pwm_pkg::M_FALL && !node_settled[g] && mcnt_q >= act_cyc)
            |=> eff_status_q[g][hb_pwm_pkg::TFALL_LSB +: 8] == 8'h00)
            else $error("missed fall end not reported as zero");
        AST_EXTREME_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
            (ms_q == hb_pwm_pkg::M_RISE && ms_d == hb_pwm_pkg::M_IDLE && extreme)
            |=> eff_status_q[g][31:24] == 8'h00 && eff_status_q[g][15:8] == 8'h00)
            else $error("switching times not zero at extreme duty");
        AST_STS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
            (ms_q == hb_pwm_pkg::M_IDLE) |=> $stable(eff_status_q[g]))
            else $error("status changed without a measurement");
        COV_FW: cover property (@(posedge pclk) disable iff (!presetn) $rose(fw_on_q));
        COV_SWAP: cover property (@(posedge pclk) disable iff (!presetn) swap && cmd_q);
        COV_EXT: cover property (@(posedge pclk) disable iff (!presetn) extreme && cmd_q);
    end
endmodule : halfbridge_pwm_freewheel_ctrl

// ==== hw/hb_pwm_pkg.sv ====
// Purpose: Shared constants for the half-bridge PWM and freewheel controller.
// Assumes: pclk at 10 MHz; registers reached over APB with 32-bit data.
// Notes:   Guard times are held in pclk cycles by the timing register.
package hb_pwm_pkg;
    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS  = 100;
    localparam int CCP_ACT_RST_NS = 1000;
    localparam int CCP_FW_RST_NS  = 1000;
    localparam int BLANK_RST_NS   = 2000;
    localparam logic [7:0] CCP_ACT_RST_CYC =
        8'((CCP_ACT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CCP_FW_RST_CYC =
        8'((CCP_FW_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] BLANK_RST_CYC =
        8'((BLANK_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] HB_CFG_BASE  = 8'h00;
    localparam logic [7:0] GLOBAL_CFG   = 8'h10;
    localparam logic [7:0] TIMING_CFG   = 8'h14;
    localparam logic [7:0] EFF_STS_BASE = 8'h20;

    // Half-bridge configuration fields.
    localparam int MODE_LSB  = 0;
    localparam int AFW_BIT   = 2;
    localparam int DCHG_LSB  = 8;
    // Global configuration fields.
    localparam int GENCHK_BIT = 0;
    localparam int PDCHG_LSB  = 8;
    // Timing fields.
    localparam int ACT_LSB   = 0;
    localparam int FW_LSB    = 8;
    localparam int BLANK_LSB = 16;
    // Status fields.
    localparam int TFALL_LSB = 0;
    localparam int TRISE_LSB = 8;
    localparam int TDOFF_LSB = 16;
    localparam int TDON_LSB  = 24;

    localparam logic [31:0] HB_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] GLOBAL_RST = 32'h0000_0000;
    localparam logic [31:0] TIMING_RST = {8'h00, BLANK_RST_CYC, CCP_FW_RST_CYC,
                                          CCP_ACT_RST_CYC};

    // ****************************************************************
    // Modes and states
    // ****************************************************************
    localparam logic [1:0] MODE_LS_PWM = 2'h1;
    localparam logic [1:0] MODE_HS_PWM = 2'h2;

    typedef enum logic [2:0] {M_IDLE, M_TDON, M_RISE, M_TDOFF, M_FALL} meas_state_e;
endpackage : hb_pwm_pkg

// ==== hw/dchg_decode.sv ====
// Purpose: Decodes a 6-bit discharge current code into a nominal current.
// Assumes: Output is in units of 10 uA.
// Notes:   Pure lookup, no state.
`timescale 1ns/1ps
module dchg_decode (
    input  wire logic [5:0]  code,
    output logic      [13:0] current_10ua
);
    // ****************************************************************
    // Nominal current table, strictly increasing
    // ****************************************************************
    localparam logic [13:0] TABLE [64] = '{
        14'd50,   14'd65,   14'd85,   14'd110,  14'd135,  14'd170,  14'd210,  14'd250,
        14'd310,  14'd370,  14'd430,  14'd500,  14'd570,  14'd650,  14'd730,  14'd820,
        14'd920,  14'd1020, 14'd1120, 14'd1230, 14'd1350, 14'd1480, 14'd1610, 14'd1740,
        14'd1880, 14'd2030, 14'd2190, 14'd2350, 14'd2520, 14'd2690, 14'd2860, 14'd3040,
        14'd3220, 14'd3400, 14'd3580, 14'd3760, 14'd3940, 14'd4130, 14'd4320, 14'd4510,
        14'd4700, 14'd4900, 14'd5100, 14'd5300, 14'd5500, 14'd5700, 14'd5900, 14'd6110,
        14'd6320, 14'd6540, 14'd6770, 14'd7000, 14'd7240, 14'd7480, 14'd7720, 14'd7960,
        14'd8210, 14'd8460, 14'd8710, 14'd8960, 14'd9220, 14'd9480, 14'd9740, 14'd10000
    };

    assign current_10ua = TABLE[code];
endmodule : dchg_decode

// ==== testbench/hb_bridge_model.sv ====
// Purpose: Behavioural switch nodes of four half-bridges.
// Assumes: Node leaves its rail 3 cycles and settles 6 cycles after a gate turns on.
// Notes:   With slow high the node never settles, like a weak gate drive.
`timescale 1ns/1ps
module hb_bridge_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] hs_gate_on,
    input  wire logic [3:0] ls_gate_on,
    input  wire logic       slow,
    output logic      [3:0] node_moving,
    output logic      [3:0] node_settled
);
    // ****************************************************************
    // Switch node timing
    // ****************************************************************
    logic [7:0] g_q;
    logic [3:0] cnt_q [4];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            g_q <= 8'h00;
            for (int i = 0; i < 4; i++) cnt_q[i] <= 4'hf;
        end else begin
            g_q <= {hs_gate_on, ls_gate_on};
            for (int i = 0; i < 4; i++) begin
                // Dropping the freewheel gate leaves the node held by the diode,
                // so only a gate turning on restarts the node timing.
                if ((hs_gate_on[i] && !g_q[i+4]) || (ls_gate_on[i] && !g_q[i])) begin
                    cnt_q[i] <= 4'h0;
                end else if (cnt_q[i] != 4'hf) begin
                    cnt_q[i] <= cnt_q[i] + 4'h1;
                end
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            node_settled[i] = (cnt_q[i] >= 4'h5) && !slow;
            node_moving[i]  = (cnt_q[i] >= 4'h2) && !node_settled[i];
        end
    end
endmodule : hb_bridge_model

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench of the half-bridge PWM controller.
// Assumes: Guards set to active 4, freewheel 3, blank 20 cycles.
// Notes:   Gate counts are taken on one randomly chosen half-bridge.
`timescale 1ns/1ps
module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er;
    logic [3:0]  pwm_in = 4'h0, gen_in = 4'h0, hs, ls, mv, st;
    logic [13:0] dc [4];
    logic [13:0] pdc, prev;
    int          err_total = 0, total_checks = 0, cyc = 0, hb = 0;
    int          hs_c, ls_c, ov_c, dl;
    logic        mon = 1'b0;

    always #50 pclk = ~pclk;

    halfbridge_pwm_freewheel_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_in(pwm_in),
        .motor_generating(gen_in), .node_moving(mv), .node_settled(st),
        .hs_gate_on(hs), .ls_gate_on(ls), .discharge_current(dc),
        .predischarge_current(pdc));
    hb_bridge_model bridge (.pclk(pclk), .presetn(presetn), .hs_gate_on(hs),
        .ls_gate_on(ls), .slow(slow), .node_moving(mv), .node_settled(st));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    always @(posedge pclk) begin
        cyc++;
        if (mon) begin
            hs_c += hs[hb];
            ls_c += ls[hb];
            ov_c += hs[hb] & ls[hb];
        end
        if (cyc == 60000) begin
            err_total++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        total_checks++;
        if (got !== ex) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cfg(input logic [1:0] md, input logic af, input logic gn);
        apb(1'b1, 8'(4 * hb), {18'h0, 6'h00, 5'h00, af, md});
        apb(1'b1, 8'h10, {31'h0, gn});
        gen_in <= {4{gn}};
    endtask : cfg

    task automatic run(input int on, input int off, input int np);
        hs_c = 0;
        ls_c = 0;
        ov_c = 0;
        mon = 1'b1;
        repeat (np) begin
            @(posedge pclk);
            pwm_in[hb] <= 1'b1;
            repeat (on - 1) @(posedge pclk);
            @(posedge pclk);
            pwm_in[hb] <= 1'b0;
            repeat (off - 1) @(posedge pclk);
        end
        repeat (20) @(posedge pclk);
        mon = 1'b0;
        apb(1'b0, 8'h20 + 8'(4 * hb), 32'h0);
    endtask : run

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h60a5));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h14, 32'h0);
        chk("timing reset", hb_pwm_pkg::TIMING_RST, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        apb(1'b1, 8'h20, 32'hffff_ffff);
        apb(1'b0, 8'h20, 32'h0);
        chk("status read only", 32'h0, rd);
        prev = 14'h0;
        for (int c = 0; c < 64; c++) begin
            hb = $urandom_range(3);
            apb(1'b1, 8'(4 * hb), {18'h0, 6'(c), 8'h00});
            apb(1'b1, 8'h10, {18'h0, 6'(c), 8'h00});
            // The write lands on the access edge; compare once it has settled.
            @(posedge pclk);
            chk("discharge rising", 32'h1, {31'h0, dc[hb] > prev});
            chk("predischarge", {18'h0, dc[hb]}, {18'h0, pdc});
            prev = dc[hb];
        end
        chk("top discharge", 32'd10000, {18'h0, prev});
        apb(1'b1, 8'h14, {8'h00, 8'd20, 8'd3, 8'd4});
        hb = $urandom_range(3);
        for (int m = 1; m < 3; m++) begin
            cfg(2'(m), 1'b1, 1'b0);
            run(30, 3, 6);
            chk("opposite gate", 32'h0, m == 2 ? ls_c : hs_c);
            chk("selected gate", 32'h1, (m == 2 ? hs_c : ls_c) > 0);
        end
        @(posedge pclk);
        pwm_in[hb] <= 1'b1;
        dl = 0;
        while (hs[hb] !== 1'b1 && dl < 20) begin
            @(posedge pclk);
            dl++;
        end
        chk("command shift", 32'h1, dl >= 4 && dl <= 6);
        repeat (30) @(posedge pclk);
        pwm_in[hb] <= 1'b0;
        run(30, 5, 6);
        chk("short off time", 32'h0, ls_c);
        run(2, 30, 6);
        chk("low duty", 32'h0, ls_c);
        chk("extreme status", 32'h0, rd);
        cfg(2'h2, 1'b0, 1'b0);
        run(30, 30, 6);
        chk("freewheel disabled", 32'h0, ls_c);
        cfg(2'h2, 1'b1, 1'b0);
        run($urandom_range(40, 15), $urandom_range(40, 15), 8);
        chk("load freewheel", 32'h1, ls_c > 0);
        chk("load overlap", 32'h0, ov_c);
        chk("rise measured", 32'h1, rd[15:8] != 8'h00);
        dl = rd;
        apb(1'b0, 8'h20 + 8'(4 * hb), 32'h0);
        chk("status held", dl, rd);
        cfg(2'h1, 1'b1, 1'b1);
        run($urandom_range(40, 15), $urandom_range(40, 15), 8);
        chk("generator gates", 32'h1, hs_c > 0 && ls_c > 0);
        chk("generator overlap", 32'h0, ov_c);
        chk("generator delay", 32'h1, rd[31:24] != 8'h00);
        cfg(2'h2, 1'b1, 1'b0);
        slow <= 1'b1;
        run(30, 30, 6);
        chk("rise timeout", 32'h0, rd[15:8]);
        chk("fall timeout", 32'h0, rd[7:0]);
        close_out();
    end
endmodule : tb
